// *** verification/amr_adc_monitor1_test.sv ***
// Purpose: Self-checking bench of the converter monitor 1 and result register block
// Assumes: Register port with one-cycle strobes, read data one cycle after the read strobe
// Notes:   All expectations are built from the register layout and the comparison limit
`default_nettype none

module amr_adc_monitor1_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_clk;
  logic i_resetn;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [31:0] o_rdata;
  amr_pkg::amr_conv_s i_conv;
  logic [9:0] i_limit;
  logic o_monitor1_hit;
  logic o_irq;
  int mismatches;
  int comparisons;
  int cycles;
  logic [31:0] rd;
  logic hit;
  logic [7:0] addr;
  logic [3:0] tgt;
  // Monitor cases: configuration, target, value, expected hit
  logic [20:0] cases [9] = '{
    {6'h01, 4'h0, 10'h064, 1'b1}, {6'h01, 4'h0, 10'h12C, 1'b0}, {6'h01, 4'h0, 10'h0C8, 1'b0},
    {6'h01, 4'h0, 10'h0C7, 1'b1}, {6'h21, 4'h0, 10'h0C9, 1'b1}, {6'h21, 4'h0, 10'h0C8, 1'b0},
    {6'h21, 4'h0, 10'h064, 1'b0}, {6'h20, 4'h0, 10'h12C, 1'b0}, {6'h00, 4'h0, 10'h064, 1'b0}};

  amr_adc_monitor1 uut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_conv(i_conv), .i_limit(i_limit),
    .o_monitor1_hit(o_monitor1_hit), .o_irq(o_irq));

  // Clock of 4 ns period
  always #2 i_clk = ~i_clk;

  // Cuts a hung run short
  always @(posedge i_clk) begin
    cycles++;
    if (cycles >= 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  // Compares one value and counts the outcome
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  // One conversion strobe; the hit pulse is sampled two edges later
  task automatic convert(input logic [3:0] t, input logic [9:0] v, output logic h);
    @(posedge i_clk);
    i_conv <= {1'b1, t, v};
    @(posedge i_clk);
    i_conv.valid <= 1'b0;
    @(posedge i_clk);
    #1;
    h = o_monitor1_hit;
  endtask

  function automatic logic [31:0] res_word(input logic [9:0] v, input logic ovr, input logic st);
    return {16'h0000, v, 4'h0, ovr, st};
  endfunction

  task automatic do_reset();
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
  endtask

  // Reset values, reserved bits and unmapped places
  task automatic test_regs();
    reg_read(amr_pkg::OFF_MON1_CFG, rd);
    check(rd, 32'h0000_0000);
    reg_read(amr_pkg::OFF_RESULT_ZERO, rd);
    check(rd, 32'h0000_0000);
    reg_read(amr_pkg::OFF_RESULT_ONE, rd);
    check(rd, 32'h0000_0000);
    check({31'h0, o_irq}, 32'h0000_0000);
    reg_write(amr_pkg::OFF_MON1_CFG, 32'hFFFF_FFFF);
    reg_read(amr_pkg::OFF_MON1_CFG, rd);
    check(rd, 32'h0000_003F);
    reg_write(8'h40, 32'h0000_0000);
    reg_read(8'h40, rd);
    check(rd, 32'h0000_0000);
    reg_read(amr_pkg::OFF_MON1_CFG, rd);
    check(rd, 32'h0000_003F);
    reg_write(amr_pkg::OFF_MON1_CFG, 32'h0000_0000);
  endtask

  // Store, overrun and clear on read for both result registers
  task automatic test_results();
    for (int i = 0; i < 2; i++) begin
      addr = i ? amr_pkg::OFF_RESULT_ONE : amr_pkg::OFF_RESULT_ZERO;
      tgt = i ? amr_pkg::TGT_ONE : amr_pkg::TGT_ZERO;
      convert(tgt, 10'h3FF, hit);
      check({31'h0, hit}, 32'h0000_0000);
      reg_read(addr, rd);
      check(rd, res_word(10'h3FF, 1'b0, 1'b1));
      reg_read(addr, rd);
      check(rd, res_word(10'h3FF, 1'b0, 1'b0));
      convert(tgt, 10'h155, hit);
      convert(tgt, 10'h2AA, hit);
      convert(4'h2, 10'h001, hit);
      reg_write(addr, 32'hFFFF_FFFF);
      reg_read(addr, rd);
      check(rd, res_word(10'h2AA, 1'b1, 1'b1));
      reg_read(addr, rd);
      check(rd, res_word(10'h2AA, 1'b0, 1'b0));
      // Store, then read in the very next cycle
      @(posedge i_clk);
      i_conv <= {1'b1, tgt, 10'h0F0};
      @(posedge i_clk);
      i_conv.valid <= 1'b0;
      i_rd <= 1'b1;
      i_addr <= addr;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      check(o_rdata, res_word(10'h0F0, 1'b0, 1'b1));
      reg_read(addr, rd);
      check(rd, res_word(10'h0F0, 1'b0, 1'b0));
    end
  endtask

  // Direction, enable and every select code against limit 0x0C8
  task automatic test_monitor();
    foreach (cases[i]) begin
      reg_write(amr_pkg::OFF_MON1_CFG, {26'h0, cases[i][20:15]});
      convert(cases[i][14:11], cases[i][10:1], hit);
      check({31'h0, hit}, {31'h0, cases[i][0]});
    end
    for (int s = 0; s < 16; s++) begin
      reg_write(amr_pkg::OFF_MON1_CFG, {26'h0, 1'b1, s[3:0], 1'b1});
      convert(s[3] ? 4'hB : s[3:0], 10'h3FF, hit);
      check({31'h0, hit}, 32'h0000_0001);
      convert(s[3] ? 4'h6 : (s[3:0] ^ 4'h1), 10'h3FF, hit);
      check({31'h0, hit}, 32'h0000_0000);
    end
  endtask

  // Sticky status, enable mask and clear of the interrupt
  task automatic test_irq();
    reg_read(amr_pkg::OFF_RESULT_ONE, rd);
    reg_write(amr_pkg::OFF_INT_ENABLE, 32'h0000_0000);
    reg_write(amr_pkg::OFF_INT_CLEAR, 32'h0000_0007);
    reg_read(amr_pkg::OFF_INT_STATUS, rd);
    check(rd, 32'h0000_0000);
    reg_write(amr_pkg::OFF_MON1_CFG, 32'h0000_0023);
    convert(amr_pkg::TGT_ONE, 10'h12C, hit);
    reg_read(amr_pkg::OFF_INT_STATUS, rd);
    check(rd, 32'h0000_0001);
    check({31'h0, o_irq}, 32'h0000_0000);
    reg_write(amr_pkg::OFF_INT_ENABLE, 32'h0000_0001);
    @(posedge i_clk);
    #1;
    check({31'h0, o_irq}, 32'h0000_0001);
    reg_write(amr_pkg::OFF_INT_CLEAR, 32'h0000_0001);
    reg_read(amr_pkg::OFF_INT_STATUS, rd);
    check(rd, 32'h0000_0000);
    check({31'h0, o_irq}, 32'h0000_0000);
    convert(amr_pkg::TGT_ONE, 10'h064, hit);
    reg_read(amr_pkg::OFF_INT_STATUS, rd);
    check(rd, 32'h0000_0004);
    reg_write(amr_pkg::OFF_INT_ENABLE, 32'hFFFF_FFFF);
    reg_read(amr_pkg::OFF_INT_ENABLE, rd);
    check(rd, 32'h0000_0007);
    check({31'h0, o_irq}, 32'h0000_0001);
    reg_write(amr_pkg::OFF_INT_ENABLE, 32'h0000_0000);
    @(posedge i_clk);
    #1;
    check({31'h0, o_irq}, 32'h0000_0000);
    reg_read(amr_pkg::OFF_INT_CLEAR, rd);
    check(rd, 32'h0000_0000);
    reg_write(amr_pkg::OFF_MON1_CFG, 32'h0000_0021);
    do_reset();
    reg_read(amr_pkg::OFF_MON1_CFG, rd);
    check(rd, 32'h0000_0000);
    reg_read(amr_pkg::OFF_RESULT_ONE, rd);
    check(rd, 32'h0000_0000);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    i_clk = 1'b0;
    i_resetn = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_conv = '0;
    i_limit = 10'h0C8;
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    test_regs();
    test_results();
    test_monitor();
    test_irq();
    give_verdict();
  end
endmodule

`default_nettype wire

// *** verilog/amr_adc_monitor1.sv ***
// Purpose: Register side of converter monitor 1 and result registers zero and one
// Assumes: Register port strobes are one cycle, read data follow one cycle later
// Notes:   Reading a result register clears its stored and overrun flags
//
// What this block does
// - Direction bit picks below or above limit
// - Select field picks watched result register
// - Enable bit gates monitor 1 interrupt
// - Result registers hold latest 10-bit result
// - Register zero overrun set, cleared by read
// - Register one overrun set, cleared by read
// - Register zero stored flag, cleared by read
// - Register one stored flag, cleared by read
//
// The implementer's own choices: the register offsets and the plain strobed port.
`default_nettype none

module amr_adc_monitor1 (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire amr_pkg::amr_conv_s i_conv,
  input wire logic [9:0] i_limit,
  output logic o_monitor1_hit,
  output logic o_irq
);

  // Configuration and results
  amr_pkg::amr_mon_cfg_s cfg_reg;
  amr_pkg::amr_result_s res_zero_reg;
  amr_pkg::amr_result_s res_one_reg;
  amr_pkg::amr_result_s res_zero_next;
  amr_pkg::amr_result_s res_one_next;

  // Interrupt bank
  logic [2:0] int_status_reg;
  logic [2:0] int_status_next;
  logic [2:0] int_enable_reg;
  logic [2:0] int_enable_next;
  logic [2:0] events;

  // Decoded strobes
  logic wr_cfg;
  logic wr_clear;
  logic wr_enable;
  logic rd_zero;
  logic rd_one;
  logic store_zero;
  logic store_one;
  logic ovr_set_zero;
  logic ovr_set_one;
  logic mon_hit;
  logic [31:0] rd_mux;
  logic first_cycle_reg;

  // Shape a result record into its register word, upper bits zero
  function automatic logic [31:0] pack_result(input amr_pkg::amr_result_s r);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[amr_pkg::RES_VAL_MSB:amr_pkg::RES_VAL_LSB] = r.value;
    w[amr_pkg::RES_OVR_BIT] = r.overrun;
    w[amr_pkg::RES_STORED_BIT] = r.stored;
    return w;
  endfunction

  // Next state of one result register; a new store beats a same-cycle read
  function automatic amr_pkg::amr_result_s next_result(
    input amr_pkg::amr_result_s r,
    input logic store,
    input logic [9:0] value,
    input logic read
  );
    amr_pkg::amr_result_s n;
    n = r;
    if (store) begin
      n.value = value;
    end
    n.stored = store | (r.stored & ~read);
    n.overrun = (store & r.stored & ~read) | (r.overrun & ~read);
    return n;
  endfunction

  // Overrun event of one register: a store over an unread result
  function automatic logic overrun_event(
    input amr_pkg::amr_result_s r,
    input logic store,
    input logic read
  );
    return store & r.stored & ~read;
  endfunction

  // Register port decode
  assign wr_cfg = i_wr && (i_addr == amr_pkg::OFF_MON1_CFG);
  assign wr_clear = i_wr && (i_addr == amr_pkg::OFF_INT_CLEAR);
  assign wr_enable = i_wr && (i_addr == amr_pkg::OFF_INT_ENABLE);
  assign rd_zero = i_rd && (i_addr == amr_pkg::OFF_RESULT_ZERO);
  assign rd_one = i_rd && (i_addr == amr_pkg::OFF_RESULT_ONE);

  // Converter stores into register zero or one
  assign store_zero = i_conv.valid && (i_conv.target == amr_pkg::TGT_ZERO);
  assign store_one = i_conv.valid && (i_conv.target == amr_pkg::TGT_ONE);

  // Monitor 1 comparator
  amr_monitor_cmp u_cmp (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_cfg(cfg_reg),
    .i_conv(i_conv),
    .i_limit(i_limit),
    .o_hit(mon_hit)
  );

  // Configuration register, only bits 5..0 are kept
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_reg <= amr_pkg::amr_mon_cfg_s'(amr_pkg::CFG_RESET);
    end else if (wr_cfg) begin
      cfg_reg <= amr_pkg::amr_mon_cfg_s'(i_wdata[amr_pkg::CFG_W-1:0]);
    end
  end

  // Result next values
  always_comb begin
    res_zero_next = next_result(res_zero_reg, store_zero, i_conv.value, rd_zero);
    res_one_next = next_result(res_one_reg, store_one, i_conv.value, rd_one);
  end

  // Result register zero
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      res_zero_reg <= amr_pkg::amr_result_s'(amr_pkg::RES_RESET);
    end else begin
      res_zero_reg <= res_zero_next;
    end
  end

  // Result register one
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      res_one_reg <= amr_pkg::amr_result_s'(amr_pkg::RES_RESET);
    end else begin
      res_one_reg <= res_one_next;
    end
  end

  // Interrupt events
  assign ovr_set_zero = overrun_event(res_zero_reg, store_zero, rd_zero);
  assign ovr_set_one = overrun_event(res_one_reg, store_one, rd_one);
  always_comb begin
    events = 3'h0;
    events[amr_pkg::EVT_MON1] = mon_hit;
    events[amr_pkg::EVT_OVR_ZERO] = ovr_set_zero;
    events[amr_pkg::EVT_OVR_ONE] = ovr_set_one;
  end

  // Sticky status, a new event wins over a same-cycle clear
  always_comb begin
    int_status_next = int_status_reg;
    if (wr_clear) begin
      int_status_next = int_status_reg & ~i_wdata[amr_pkg::EVT_W-1:0];
    end
    int_status_next = int_status_next | events;
  end

  // Enable next value
  always_comb begin
    int_enable_next = int_enable_reg;
    if (wr_enable) begin
      int_enable_next = i_wdata[amr_pkg::EVT_W-1:0];
    end
  end

  // Status and enable registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      int_status_reg <= amr_pkg::EVT_RESET;
      int_enable_reg <= amr_pkg::EVT_RESET;
    end else begin
      int_status_reg <= int_status_next;
      int_enable_reg <= int_enable_next;
    end
  end

  // Interrupt line follows the enabled status bits
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(int_status_next & int_enable_next);
    end
  end

  // Monitor hit pulse brought out through a flop
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_monitor1_hit <= 1'b0;
    end else begin
      o_monitor1_hit <= mon_hit;
    end
  end

  // Read multiplexer, unmapped and write-only addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_addr)
      amr_pkg::OFF_MON1_CFG: begin
        rd_mux[amr_pkg::CFG_W-1:0] = cfg_reg;
      end
      amr_pkg::OFF_RESULT_ZERO: begin
        rd_mux = pack_result(res_zero_reg);
      end
      amr_pkg::OFF_RESULT_ONE: begin
        rd_mux = pack_result(res_one_reg);
      end
      amr_pkg::OFF_INT_STATUS: begin
        rd_mux[amr_pkg::EVT_W-1:0] = int_status_reg;
      end
      amr_pkg::OFF_INT_ENABLE: begin
        rd_mux[amr_pkg::EVT_W-1:0] = int_enable_reg;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read data stand for one cycle after the strobe, else zero
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= amr_pkg::RDATA_IDLE;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end else begin
      o_rdata <= amr_pkg::RDATA_IDLE;
    end
  end

  // Marks the first clock after reset release, checking aid
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      first_cycle_reg <= 1'b1;
    end else begin
      first_cycle_reg <= 1'b0;
    end
  end

  // Stored result and flag after a conversion into register zero
  AST_STORE_ZERO: assert property (@(posedge i_clk) disable iff (!i_resetn)
    store_zero |=> (res_zero_reg.stored && res_zero_reg.value == $past(i_conv.value)))
    else $error("register zero did not take the new result");

  // Store into register one, then a read shows the value and flag
  AST_STORE_ONE_READ: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (store_one ##1 (rd_one && !store_one)) |=>
      (o_rdata[15:6] == $past(i_conv.value, 2) && o_rdata[0] && !res_one_reg.stored))
    else $error("register one read did not return or clear the stored result");

  // Overrun of register zero set on a store over an unread result
  AST_OVR_ZERO_SET: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (store_zero && res_zero_reg.stored && !rd_zero) |=> (res_zero_reg.overrun && int_status_reg[1]))
    else $error("register zero overrun not flagged");

  // Any read of register zero clears its overrun flag
  AST_OVR_ZERO_CLR: assert property (@(posedge i_clk) disable iff (!i_resetn)
    rd_zero |=> !res_zero_reg.overrun)
    else $error("register zero overrun survived a read");

  // Overrun of register one set on a store over an unread result
  AST_OVR_ONE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (store_one && res_one_reg.stored && !rd_one) |=> (res_one_reg.overrun && int_status_reg[2]))
    else $error("register one overrun not flagged");

  // Any read of register one clears its overrun flag
  AST_OVR_ONE_CLR: assert property (@(posedge i_clk) disable iff (!i_resetn)
    rd_one |=> !res_one_reg.overrun)
    else $error("register one overrun survived a read");

  // Stored flag of register zero drops after a plain read
  AST_STORED_ZERO_CLR: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (rd_zero && !store_zero) |=> !res_zero_reg.stored)
    else $error("register zero stored flag survived a read");

  // Reserved bits of the configuration and result words read zero
  AST_RESERVED_ZERO: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $past(i_rd) |-> (o_rdata[31:16] == 16'h0000 &&
      ($past(i_addr) != amr_pkg::OFF_MON1_CFG || o_rdata[15:6] == 10'h000) &&
      (($past(i_addr) != amr_pkg::OFF_RESULT_ZERO && $past(i_addr) != amr_pkg::OFF_RESULT_ONE) ||
        o_rdata[5:2] == 4'h0)))
    else $error("reserved bits read non-zero");

  // Configuration, both results and the interrupt line are zero on the first clock after reset
  AST_RESET_ZERO: assert property (@(posedge i_clk) disable iff (!i_resetn)
    first_cycle_reg |-> (cfg_reg == '0 && res_zero_reg == '0 && res_one_reg == '0 && !o_irq))
    else $error("state not zero after reset");

  // Interrupt line matches the enabled sticky bits
  AST_IRQ_LEVEL: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_irq == |(int_status_reg & int_enable_reg))
    else $error("interrupt line disagrees with status and enable");

  // A monitor disabled for two cycles never raises its status bit
  AST_MON_STATUS: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (!cfg_reg.en ##1 (!cfg_reg.en && !int_status_reg[0])) |=> !int_status_reg[0])
    else $error("monitor status set while disabled");

  // Register one takes a new result and sets its stored flag
  AST_STORE_ONE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    store_one |=> (res_one_reg.stored && res_one_reg.value == $past(i_conv.value)))
    else $error("register one did not take the new result");

  // Stored flag of register one drops after a plain read
  AST_STORED_ONE_CLR: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (rd_one && !store_one) |=> !res_one_reg.stored)
    else $error("register one stored flag survived a read");

  // Result values are read-only: only the converter changes them
  AST_RESULT_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (!store_zero && !store_one) |=> (res_zero_reg.value == $past(res_zero_reg.value) &&
      res_one_reg.value == $past(res_one_reg.value)))
    else $error("result value changed without a conversion");

  // A configuration write keeps bits 5..0 only
  AST_CFG_WRITE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    wr_cfg |=> (cfg_reg == $past(i_wdata[5:0])))
    else $error("configuration write not taken as written");

  // Read data fall back to zero outside the cycle after a read
  AST_RDATA_IDLE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_rd |=> (o_rdata == 32'h0000_0000))
    else $error("read data stood longer than one cycle");

  // A new event always lands in the sticky status, even beside a clear
  AST_STATUS_SET: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (events != 3'h0) |=> ((int_status_reg & $past(events)) == $past(events)))
    else $error("interrupt event lost");

  // The hit output follows the internal hit one clock later
  AST_HIT_OUT: assert property (@(posedge i_clk) disable iff (!i_resetn)
    mon_hit |=> o_monitor1_hit)
    else $error("monitor hit not brought out");

endmodule

`default_nettype wire

// *** verilog/amr_monitor_cmp.sv ***
// Purpose: Monitor 1 comparator, flags a stored result above or below the limit
// Assumes: Conversion events arrive as one-cycle valid strobes
// Notes:   Hit is a one-cycle pulse one clock after the matching conversion
`default_nettype none

module amr_monitor_cmp (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire amr_pkg::amr_mon_cfg_s i_cfg,
  input wire amr_pkg::amr_conv_s i_conv,
  input wire logic [9:0] i_limit,
  output logic o_hit
);

  logic sel_hit;
  logic cmp_true;

  // Codes 0..7 pick one register, any 1xxx picks the special register
  function automatic logic sel_match(input logic [3:0] sel, input logic [3:0] tgt);
    if (sel[amr_pkg::TGT_SPECIAL_BIT]) begin
      sel_match = tgt[amr_pkg::TGT_SPECIAL_BIT];
    end else begin
      sel_match = (tgt == sel);
    end
  endfunction

  // Target decode and direction compare
  assign sel_hit = sel_match(i_cfg.sel, i_conv.target);
  assign cmp_true = i_cfg.dir ? (i_conv.value > i_limit) : (i_conv.value < i_limit);

  // Hit pulse only while the monitor is enabled
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hit <= 1'b0;
    end else begin
      o_hit <= i_cfg.en && i_conv.valid && sel_hit && cmp_true;
    end
  end

  AST_MON_BELOW: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_cfg.en && i_conv.valid && sel_hit && !i_cfg.dir && i_conv.value < i_limit) |=> o_hit)
    else $error("monitor missed a result below the limit");
  AST_MON_ABOVE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_conv.valid && !i_cfg.dir && i_conv.value >= i_limit) |=> !o_hit)
    else $error("monitor fired on a result not below the limit");
  AST_MON_SEL: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_conv.valid && i_cfg.sel[3] && !i_conv.target[3]) |=> !o_hit)
    else $error("special select fired on an ordinary register");
  AST_MON_OFF: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_cfg.en |=> !o_hit)
    else $error("monitor fired while disabled");

endmodule

`default_nettype wire

// *** verilog/amr_pkg.sv ***
// Purpose: Shared constants and carriers of the converter monitor 1 and result block
// Assumes: 32-bit register port, one clock, byte addresses on an 8-bit address
// Notes:   Result value sits in bits 15..6 of each result register
`default_nettype none

package amr_pkg;

  // Register byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_MON1_CFG = 8'h00;
  localparam logic [7:0] OFF_RESULT_ZERO = 8'h04;
  localparam logic [7:0] OFF_RESULT_ONE = 8'h08;
  localparam logic [7:0] OFF_INT_STATUS = 8'h0C;
  localparam logic [7:0] OFF_INT_CLEAR = 8'h10;
  localparam logic [7:0] OFF_INT_ENABLE = 8'h14;

  // Monitor 1 configuration layout
  localparam int unsigned CFG_W = 6;
  localparam int unsigned CFG_EN_BIT = 0;
  localparam int unsigned CFG_SEL_LSB = 1;
  localparam int unsigned CFG_SEL_MSB = 4;
  localparam int unsigned CFG_DIR_BIT = 5;
  localparam logic [5:0] CFG_RESET = 6'h00;

  // Result register layout
  localparam int unsigned RES_W = 10;
  localparam int unsigned RES_VAL_LSB = 6;
  localparam int unsigned RES_VAL_MSB = 15;
  localparam int unsigned RES_OVR_BIT = 1;
  localparam int unsigned RES_STORED_BIT = 0;
  localparam logic [11:0] RES_RESET = 12'h000;

  // Converter target codes, 1xxx is the special result register
  localparam logic [3:0] TGT_ZERO = 4'h0;
  localparam logic [3:0] TGT_ONE = 4'h1;
  localparam int unsigned TGT_SPECIAL_BIT = 3;

  // Interrupt event bits
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EVT_MON1 = 0;
  localparam int unsigned EVT_OVR_ZERO = 1;
  localparam int unsigned EVT_OVR_ONE = 2;
  localparam logic [2:0] EVT_RESET = 3'h0;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic [3:0] target;
    logic [9:0] value;
  } amr_conv_s;

  // Same bit order as the configuration register bits 5..0
  typedef struct packed {
    logic dir;
    logic [3:0] sel;
    logic en;
  } amr_mon_cfg_s;

  typedef struct packed {
    logic [9:0] value;
    logic overrun;
    logic stored;
  } amr_result_s;

endpackage

`default_nettype wire
